// [core/cmph_top.sv]
// Command-mode parameter handler: exit, timeout, output-one pin and signal strength
`timescale 1ns/1ns
`include "cmph_map.svh"

module cmph_top
    import cmph_pkg::*;
#(
    parameter int TICK_CYCLES = (`CMPH_CLK_HZ / 1000) * `CMPH_TICK_MS
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // Command mode entry and activity
    input  wire logic        enterCmd,
    input  wire logic        rxCmdChar,
    // Decoded command
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdCode,
    input  wire logic        cmdWrite,
    input  wire logic [15:0] cmdParam,
    input  wire logic        cmdText,
    input  wire logic [1:0]  numberBaseSetting,
    // Radio receive report
    input  wire logic        rssiUpdate,
    input  wire logic [7:0]  rssiMagIn,
    // Sources for the output-one pin
    input  wire logic        ctsAssert,
    input  wire logic        txActive,
    // Mode and answers
    output logic             cmdModeActive,
    output logic             exitPulse,
    output logic             rspValid,
    output logic [15:0]      rspData,
    output logic [1:0]       rspLen,
    output logic             rspError,
    output logic             textValid,
    output logic [7:0]       textData,
    input  wire logic        textReady,
    output logic             textBusy,
    output logic             generalOutputOne,
    output logic [2:0]       out1Config,
    output logic [15:0]      cmdModeTimeout
);
    //------------
    // State
    //------------
    cmph_mode_t  mode_q;
    logic [2:0]  out1Cfg_q;
    logic [15:0] timeout_q;
    logic [7:0]  rssi_q;
    logic        rssiSeen_q;
    logic        rspValid_q;
    logic [15:0] rspData_q;
    logic [1:0]  rspLen_q;
    logic        rspError_q;
    logic        exit_q;
    logic        pin_q;
    logic        fmtStart_q;
    logic        expire;
    logic        cmdAct;
    logic        isExit;
    logic        isOut1;
    logic        isTime;
    logic        isRssi;
    logic [7:0]  rssiClamp;
    logic [15:0] rssiWord;

    cmph_fmt_if fIf ();

    //------------
    // Command decode
    //------------

    // Commands only count while the module is in command mode
    assign cmdAct = cmdValid && (mode_q == CMPH_CMD);
    assign isExit = cmdAct && (cmdCode == `CMPH_CMD_EXIT);
    assign isOut1 = cmdAct && (cmdCode == `CMPH_CMD_OUT1);
    assign isTime = cmdAct && (cmdCode == `CMPH_CMD_TIMEOUT);
    assign isRssi = cmdAct && (cmdCode == `CMPH_CMD_RSSI);

    //------------
    // Mode control
    //------------

    // Exit and expiry win over a same-cycle entry; data resumes at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= CMPH_DATA;
        end else begin
            case (mode_q)
                CMPH_DATA: begin
                    if (enterCmd) begin
                        mode_q <= CMPH_CMD;
                    end
                end
                CMPH_CMD: begin
                    if (isExit) begin
                        mode_q <= CMPH_DATA;
                    end else if (expire) begin
                        mode_q <= CMPH_DATA;
                    end
                end
                default: mode_q <= CMPH_DATA;
            endcase
        end
    end

    // One pulse for either kind of exit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exit_q <= 1'b0;
        end else begin
            exit_q <= (mode_q == CMPH_CMD) && (isExit || expire);
        end
    end

    //------------
    // Inactivity timer
    //------------

    // A character or a whole command restarts the idle count
    cmph_inact_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) uTimer (
        .clk     (clk),
        .resetn  (resetn),
        .run     (mode_q == CMPH_CMD),
        .restart (rxCmdChar || cmdAct),
        .limit   (timeout_q),
        .expire  (expire)
    );

    //------------
    // Parameters written by the host
    //------------

    // Out-of-range writes keep the old value and flag an error
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out1Cfg_q <= `CMPH_OUT1_CTS;
        end else if (isOut1 && cmdWrite && cmdParam <= 16'(`CMPH_OUT1_LOW)) begin
            out1Cfg_q <= cmdParam[2:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timeout_q <= `CMPH_CT_DEFAULT;
        end else if (isTime && cmdWrite && cmdParam >= `CMPH_CT_MIN) begin
            timeout_q <= cmdParam;
        end
    end

    //------------
    // Signal strength capture
    //------------

    // Clamp so a stray front-end reading never leaves the range
    always_comb begin
        rssiClamp = rssiMagIn;
        if (rssiMagIn < `CMPH_RSSI_MIN) begin
            rssiClamp = `CMPH_RSSI_MIN;
        end else if (rssiMagIn > `CMPH_RSSI_MAX) begin
            rssiClamp = `CMPH_RSSI_MAX;
        end
    end

    // The seen flag is cleared only by reset, so no set/clear race exists
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rssi_q     <= 8'h00;
            rssiSeen_q <= 1'b0;
        end else if (rssiUpdate) begin
            rssi_q     <= rssiClamp;
            rssiSeen_q <= 1'b1;
        end
    end

    assign rssiWord = rssiSeen_q ? {8'h00, rssi_q} : `CMPH_RSSI_NONE;

    //------------
    // Binary answers
    //------------

    // Answer comes one cycle after the command; writes echo nothing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rspValid_q <= 1'b0;
            rspData_q  <= 16'h0;
            rspLen_q   <= 2'h0;
            rspError_q <= 1'b0;
        end else begin
            rspValid_q <= 1'b0;
            rspError_q <= 1'b0;
            if (isOut1) begin
                rspError_q <= cmdWrite && cmdParam > 16'(`CMPH_OUT1_LOW);
                if (!cmdWrite) begin
                    rspValid_q <= 1'b1;
                    rspData_q  <= {13'h0, out1Cfg_q};
                    rspLen_q   <= `CMPH_LEN_ONE;
                end
            end else if (isTime) begin
                rspError_q <= cmdWrite && cmdParam < `CMPH_CT_MIN;
                if (!cmdWrite) begin
                    rspValid_q <= 1'b1;
                    rspData_q  <= timeout_q;
                    rspLen_q   <= `CMPH_LEN_TWO;
                end
            end else if (isRssi) begin
                // Read-only: a write is refused; text answers use the formatter
                rspError_q <= cmdWrite || (cmdText && (fIf.busy || fmtStart_q));
                if (!cmdWrite && !cmdText) begin
                    rspValid_q <= 1'b1;
                    rspData_q  <= rssiWord;
                    rspLen_q   <= `CMPH_LEN_TWO;
                end
            end else if (cmdAct && !isExit) begin
                rspError_q <= 1'b1;
            end
        end
    end

    //------------
    // Text answer
    //------------

    // A text query while a line is still going out is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fmtStart_q <= 1'b0;
        end else begin
            fmtStart_q <= isRssi && !cmdWrite && cmdText && !fIf.busy && !fmtStart_q;
        end
    end

    assign fIf.start   = fmtStart_q;
    assign fIf.mag     = rssi_q;
    assign fIf.none    = !rssiSeen_q;
    assign fIf.base    = numberBaseSetting;
    assign fIf.chReady = textReady;

    cmph_rssi_fmt uFmt (
        .clk    (clk),
        .resetn (resetn),
        .fi     (fIf)
    );

    //------------
    // Output-one pin
    //------------

    // Registered so the pin never glitches between sources
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_q <= 1'b1;
        end else begin
            case (out1Cfg_q)
                `CMPH_OUT1_CTS:    pin_q <= !ctsAssert;
                `CMPH_OUT1_TXE_LO: pin_q <= !txActive;
                `CMPH_OUT1_HIGH:   pin_q <= 1'b1;
                `CMPH_OUT1_TXE_HI: pin_q <= txActive;
                `CMPH_OUT1_LOW:    pin_q <= 1'b0;
                default:           pin_q <= !ctsAssert;
            endcase
        end
    end

    //------------
    // Outputs
    //------------
    assign cmdModeActive    = (mode_q == CMPH_CMD);
    assign exitPulse        = exit_q;
    assign rspValid         = rspValid_q;
    assign rspData          = rspData_q;
    assign rspLen           = rspLen_q;
    assign rspError         = rspError_q;
    assign textValid        = fIf.chValid;
    assign textData         = fIf.chData;
    assign textBusy         = fIf.busy;
    assign generalOutputOne = pin_q;
    assign out1Config       = out1Cfg_q;
    assign cmdModeTimeout   = timeout_q;
endmodule

// [core/cmph_map.svh]
// Codes, setting values, reset values and timing counts of the command-mode parameter handler
`ifndef CMPH_MAP_SVH
`define CMPH_MAP_SVH
// Binary command codes
`define CMPH_CMD_EXIT      8'h09
`define CMPH_CMD_OUT1      8'h1f
`define CMPH_CMD_TIMEOUT   8'h06
`define CMPH_CMD_RSSI      8'h36
// Output-one configuration values
`define CMPH_OUT1_CTS      3'h0
`define CMPH_OUT1_TXE_LO   3'h1
`define CMPH_OUT1_HIGH     3'h2
`define CMPH_OUT1_TXE_HI   3'h3
`define CMPH_OUT1_LOW      3'h4
// Timeout parameter in 100 ms units, tick length in ms and clock rate in Hz
`define CMPH_CT_MIN        16'h0002
`define CMPH_CT_DEFAULT    16'h00c8
`define CMPH_TICK_MS       100
`define CMPH_CLK_HZ        20000000
// Signal strength magnitudes and marker
`define CMPH_RSSI_MIN      8'h28
`define CMPH_RSSI_MAX      8'h6e
`define CMPH_RSSI_NONE     16'h8000
// Number base settings
`define CMPH_CF_UNITS      2'h0
`define CMPH_CF_HEX        2'h1
`define CMPH_CF_DEC        2'h2
// Response sizes in bytes
`define CMPH_LEN_ONE       2'h1
`define CMPH_LEN_TWO       2'h2
`endif

// [core/cmph_pkg.sv]
// Types shared by the command-mode parameter handler modules
package cmph_pkg;
    typedef enum logic {CMPH_DATA, CMPH_CMD} cmph_mode_t;
    typedef enum logic {CMPH_FMT_IDLE, CMPH_FMT_SEND} cmph_fmt_st_t;
    typedef logic [7:0] cmph_byte_t;
endpackage

// [core/cmph_fmt_if.sv]
// Link between the command handler and the text formatter
`timescale 1ns/1ns
interface cmph_fmt_if;
    import cmph_pkg::*;
    logic       start;
    cmph_byte_t mag;
    logic       none;
    logic [1:0] base;
    logic       busy;
    logic       chValid;
    logic       chReady;
    cmph_byte_t chData;
    modport ctl (output start, mag, none, base, chReady, input busy, chValid, chData);
    modport fmt (input start, mag, none, base, chReady, output busy, chValid, chData);
endinterface

// [core/cmph_inact_timer.sv]
// Command-mode inactivity timer counting 100 ms ticks
`timescale 1ns/1ns
`include "cmph_map.svh"
module cmph_inact_timer
    import cmph_pkg::*;
#(
    parameter int TICK_CYCLES = 2000000
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic [15:0] limit,
    output logic             expire
);
    logic [31:0] preCnt_q;
    logic [15:0] tickCnt_q;
    logic        tick;

    assign tick = (preCnt_q == 32'(TICK_CYCLES - 1));

    // Prescaler: any activity restarts the whole measurement
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            preCnt_q <= 32'h0;
        end else if (!run || restart || tick) begin
            preCnt_q <= 32'h0;
        end else begin
            preCnt_q <= preCnt_q + 32'h1;
        end
    end

    // Tick counter; expiry is a single pulse at the limit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tickCnt_q <= 16'h0;
        end else if (!run || restart) begin
            tickCnt_q <= 16'h0;
        end else if (tick && tickCnt_q != 16'hffff) begin
            tickCnt_q <= tickCnt_q + 16'h1;
        end
    end

    assign expire = run && !restart && tick && (tickCnt_q + 16'h1 == limit);
endmodule

// [core/cmph_rssi_fmt.sv]
// Text formatter for the signal-strength answer
`timescale 1ns/1ns
`include "cmph_map.svh"
module cmph_rssi_fmt
    import cmph_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    cmph_fmt_if.fmt   fi
);
    cmph_byte_t   text_q [8];
    logic [3:0]   len_q;
    logic [3:0]   idx_q;
    cmph_fmt_st_t st_q;
    cmph_byte_t   hund, tens, ones;
    logic         big;

    // Decimal digits of a magnitude up to 110
    assign big  = (fi.mag >= 8'd100);
    assign hund = 8'h30 + (big ? 8'h01 : 8'h00);
    assign tens = 8'h30 + 8'((fi.mag % 8'd100) / 8'd10);
    assign ones = 8'h30 + 8'(fi.mag % 8'd10);

    function automatic cmph_byte_t hexCh(input logic [3:0] n);
        hexCh = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Build the whole line at start so the source can change meanwhile
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                text_q[i] <= 8'h20;
            end
            len_q <= 4'h0;
        end else if (fi.start && st_q == CMPH_FMT_IDLE) begin
            for (int i = 0; i < 8; i++) begin
                text_q[i] <= 8'h20;
            end
            if (fi.none) begin
                text_q[0] <= 8'h38;
                text_q[1] <= 8'h30;
                text_q[2] <= 8'h30;
                text_q[3] <= 8'h30;
                text_q[4] <= 8'h0d;
                len_q     <= 4'h5;
            end else if (fi.base == `CMPH_CF_HEX) begin
                text_q[0] <= hexCh(fi.mag[7:4]);
                text_q[1] <= hexCh(fi.mag[3:0]);
                text_q[2] <= 8'h0d;
                len_q     <= 4'h3;
            end else begin
                text_q[0] <= 8'h2d;
                text_q[1] <= big ? hund : tens;
                text_q[2] <= big ? tens : ones;
                text_q[3] <= big ? ones : 8'h20;
                if (fi.base == `CMPH_CF_UNITS) begin
                    text_q[4] <= 8'h64;
                    text_q[5] <= 8'h42;
                    text_q[6] <= 8'h6d;
                    text_q[7] <= 8'h0d;
                    len_q     <= 4'h8;
                end else begin
                    text_q[4] <= 8'h0d;
                    len_q     <= 4'h5;
                end
            end
        end
    end

    // Stream one character per accepted handshake
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q  <= CMPH_FMT_IDLE;
            idx_q <= 4'h0;
        end else begin
            case (st_q)
                CMPH_FMT_IDLE: begin
                    idx_q <= 4'h0;
                    if (fi.start) begin
                        st_q <= CMPH_FMT_SEND;
                    end
                end
                CMPH_FMT_SEND: begin
                    if (fi.chReady) begin
                        idx_q <= idx_q + 4'h1;
                        if (idx_q + 4'h1 == len_q) begin
                            st_q <= CMPH_FMT_IDLE;
                        end
                    end
                end
                default: st_q <= CMPH_FMT_IDLE;
            endcase
        end
    end

    assign fi.busy    = (st_q == CMPH_FMT_SEND);
    assign fi.chValid = (st_q == CMPH_FMT_SEND);
    assign fi.chData  = text_q[idx_q[2:0]];
endmodule

// [verification/cmph_host_model.sv]
// Host-side serial model that takes the text answer characters
`timescale 1ns/1ns
module cmph_host_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       slow,
    input  wire logic       textValid,
    input  wire logic [7:0] textData,
    output logic            textReady
);
    string got = "";
    // When slow, ready every other cycle so a character must wait
    always @(negedge clk) begin
        textReady <= resetn && (!slow || textReady !== 1'b1);
    end
    // Take a character at each handshake edge
    always @(posedge clk) begin
        if (textValid === 1'b1 && textReady === 1'b1) got = {got, string'(textData)};
    end
endmodule

// [verification/cmph_top_sva.sv]
// Port checker for the command-mode parameter handler
`timescale 1ns/1ns
module cmph_top_sva #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        enterCmd,
    input wire logic        rxCmdChar,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdCode,
    input wire logic        cmdWrite,
    input wire logic [15:0] cmdParam,
    input wire logic        cmdText,
    input wire logic        rssiUpdate,
    input wire logic [7:0]  rssiMagIn,
    input wire logic        ctsAssert,
    input wire logic        txActive,
    input wire logic        cmdModeActive,
    input wire logic        exitPulse,
    input wire logic        rspValid,
    input wire logic [15:0] rspData,
    input wire logic [1:0]  rspLen,
    input wire logic        rspError,
    input wire logic        textValid,
    input wire logic        textReady,
    input wire logic        textBusy,
    input wire logic        generalOutputOne,
    input wire logic [2:0]  out1Config,
    input wire logic [15:0] cmdModeTimeout
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic        take;
    logic [31:0] lim;
    logic [31:0] idleQ;
    logic        seenQ;
    logic [7:0]  magQ;
    assign take = cmdValid && cmdModeActive;
    assign lim = 32'(cmdModeTimeout) * 32'(TICK_CYCLES);
    // Idle cycles since the last restart
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) idleQ <= '0;
        else if (!cmdModeActive || rxCmdChar || take) idleQ <= '0;
        else idleQ <= idleQ + 32'd1;
    end
    // Expected strength, clamped to its range
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seenQ <= 1'b0;
            magQ <= 8'h00;
        end else if (rssiUpdate) begin
            seenQ <= 1'b1;
            magQ <= rssiMagIn < 8'h28 ? 8'h28 : (rssiMagIn > 8'h6e ? 8'h6e : rssiMagIn);
        end
    end
    // ------------
    // Mode and timeout
    // ------------
    exit_cmd_a: assert property (take && cmdCode == 8'h09 |=> !cmdModeActive && exitPulse)
        else $error("exit ignored");
    idle_ignore_a: assert property (cmdValid && !cmdModeActive |=> !rspValid && !rspError)
        else $error("answer while idle");
    fell_pulse_a: assert property ($fell(cmdModeActive) |-> ##[0:1] exitPulse)
        else $error("no exit pulse");
    idle_bound_a: assert property (cmdModeActive |-> idleQ <= lim + 32'd2)
        else $error("timeout overran");
    exit_late_a: assert property ($fell(cmdModeActive) && !$past(cmdValid && cmdCode == 8'h09)
        |-> $past(idleQ) + 32'd3 >= $past(lim))
        else $error("timeout expired early");
    // ------------
    // Answers
    // ------------
    range_err_a: assert property (take && cmdWrite && ((cmdCode == 8'h1f && cmdParam > 16'h0004)
        || (cmdCode == 8'h06 && cmdParam < 16'h0002)) |=> rspError && $stable(out1Config)
        && $stable(cmdModeTimeout)) else $error("bad value not refused");
    rssi_ro_a: assert property (take && cmdWrite && cmdCode == 8'h36 |=> rspError && !rspValid)
        else $error("strength written");
    len_two_a: assert property (take && !cmdWrite && (cmdCode == 8'h06 || (cmdCode == 8'h36 && !cmdText))
        |=> rspValid && rspLen == 2'h2) else $error("two-byte answer wrong");
    len_one_a: assert property (take && !cmdWrite && cmdCode == 8'h1f
        |=> rspValid && rspLen == 2'h1 && rspData[2:0] == $past(out1Config)) else $error("config answer wrong");
    tmo_val_a: assert property (take && !cmdWrite && cmdCode == 8'h06
        |=> rspData == $past(cmdModeTimeout)) else $error("timeout answer wrong");
    rssi_val_a: assert property (take && !cmdWrite && !cmdText && cmdCode == 8'h36 && !rssiUpdate
        |=> rspData == (seenQ ? {8'h00, magQ} : 16'h8000)) else $error("strength answer wrong");
    text_go_a: assert property (take && !cmdWrite && cmdText && cmdCode == 8'h36 && !textBusy
        |-> ##2 textValid) else $error("no text start");
    // ------------
    // Output-one pin, once its setting has held
    // ------------
    pin_cts_a: assert property ($stable(out1Config) && out1Config == 3'h0
        |-> generalOutputOne == !$past(ctsAssert)) else $error("pin not flow control");
    pin_txe_a: assert property ($stable(out1Config) && out1Config inside {3'h1, 3'h3}
        |-> generalOutputOne == ($past(txActive) ^ (out1Config == 3'h1))) else $error("pin not tx enable");
    pin_fix_a: assert property ($stable(out1Config) && out1Config inside {3'h2, 3'h4}
        |-> generalOutputOne == (out1Config == 3'h2)) else $error("pin not at fixed level");
    enter_c: cover property (enterCmd && !cmdModeActive);
    expire_c: cover property ($fell(cmdModeActive) && !$past(cmdValid));
    text_c: cover property (textValid && textReady);
endmodule
bind cmph_top cmph_top_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (.clk, .resetn, .enterCmd, .rxCmdChar,
    .cmdValid, .cmdCode, .cmdWrite, .cmdParam, .cmdText, .rssiUpdate, .rssiMagIn, .ctsAssert, .txActive,
    .cmdModeActive, .exitPulse, .rspValid, .rspData, .rspLen, .rspError, .textValid, .textReady,
    .textBusy, .generalOutputOne, .out1Config, .cmdModeTimeout);

// [verification/tb_top.sv]
// Self-checking bench for the command-mode parameter handler
`timescale 1ns/1ns
module tb_top;
    localparam int TICK = 4;
    typedef struct {logic [7:0] c; logic w; logic [15:0] p; logic e; logic [1:0] n; logic [15:0] d;} cmph_row_t;
    logic clk = 1'b0, resetn = 1'b0, enterCmd = 1'b0, rxCmdChar = 1'b0, cmdValid = 1'b0, cmdWrite = 1'b0;
    logic cmdText = 1'b0, rssiUpdate = 1'b0, ctsAssert = 1'b0, txActive = 1'b0, slow = 1'b0, x;
    logic [7:0]  cmdCode = 8'h00, rssiMagIn = 8'h00, textData;
    logic [15:0] cmdParam = 16'h0000, rspData, cmdModeTimeout;
    logic [1:0]  numberBaseSetting = 2'h0, rspLen;
    logic [2:0]  out1Config;
    logic        cmdModeActive, exitPulse, rspValid, rspError, textValid, textReady, textBusy, generalOutputOne;
    int          failures = 0, n_checks = 0, cyc = 0, n;
    cmph_row_t rows[12] = '{
        '{8'h06, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h00c8},
        '{8'h36, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h8000},
        '{8'h1f, 1'h0, 16'h0000, 1'h0, 2'h1, 16'h0000},
        '{8'h1f, 1'h1, 16'h0005, 1'h1, 2'h0, 16'h0000},
        '{8'h06, 1'h1, 16'h0001, 1'h1, 2'h0, 16'h0000},
        '{8'h06, 1'h1, 16'h0002, 1'h0, 2'h0, 16'h0000},
        '{8'h06, 1'h0, 16'h0000, 1'h0, 2'h2, 16'h0002},
        '{8'h06, 1'h1, 16'hffff, 1'h0, 2'h0, 16'h0000},
        '{8'h06, 1'h0, 16'h0000, 1'h0, 2'h2, 16'hffff},
        '{8'h36, 1'h1, 16'h0050, 1'h1, 2'h0, 16'h0000},
        '{8'h77, 1'h0, 16'h0000, 1'h1, 2'h0, 16'h0000},
        '{8'h06, 1'h1, 16'h00c8, 1'h0, 2'h0, 16'h0000}
    };
    cmph_top #(.TICK_CYCLES(TICK)) dut_u (.clk, .resetn, .enterCmd, .rxCmdChar, .cmdValid, .cmdCode,
        .cmdWrite, .cmdParam, .cmdText, .numberBaseSetting, .rssiUpdate, .rssiMagIn, .ctsAssert, .txActive,
        .cmdModeActive, .exitPulse, .rspValid, .rspData, .rspLen, .rspError, .textValid, .textData,
        .textReady, .textBusy, .generalOutputOne, .out1Config, .cmdModeTimeout);
    cmph_host_model host_u (.clk, .resetn, .slow, .textValid, .textData, .textReady);
    // 20 MHz clock
    always #25 clk = !clk;
    // Watchdog: the run needs under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            $display("BAD %0t watchdog ran out", $time);
            stop_test;
        end
    end
    // ------------
    // Tasks
    // ------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic chks(input string g, input string e);
        n_checks++;
        if (g != e) begin
            failures++;
            $display("BAD %0t text of %0d chars, want %0d", $time, g.len(), e.len());
        end
    endtask
    // One command; its answer is settled on return
    task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] p, input logic t);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdCode = c;
        cmdWrite = w;
        cmdParam = p;
        cmdText = t;
        @(negedge clk);
        cmdValid = 1'b0;
    endtask
    task automatic enter;
        @(negedge clk);
        enterCmd = 1'b1;
        @(negedge clk);
        enterCmd = 1'b0;
        chk({15'h0, cmdModeActive}, 16'h0001, "enter");
    endtask
    task automatic upd(input logic [7:0] m);
        @(negedge clk);
        rssiUpdate = 1'b1;
        rssiMagIn = m;
        @(negedge clk);
        rssiUpdate = 1'b0;
    endtask
    // Text query; when slow, a second one is refused as busy
    task automatic txt(input logic [1:0] b, input string e, input logic s);
        numberBaseSetting = b;
        slow = s;
        host_u.got = "";
        cmd(8'h36, 1'h0, 16'h0000, 1'h1);
        if (s) begin
            cmd(8'h36, 1'h0, 16'h0000, 1'h1);
            chk({15'h0, rspError}, 16'h0001, "busy query");
        end
        for (n = 0; n < 80 && host_u.got.len() < e.len(); n++) @(negedge clk);
        chks(host_u.got, e);
        repeat (3) @(negedge clk);
        $display("text test base %0d done", b);
    endtask
    // ------------
    // Sequence
    // ------------
    initial begin
        repeat (2) @(negedge clk);
        chk({13'h0, cmdModeActive, textBusy, generalOutputOne}, 16'h0001, "reset pins");
        chk(cmdModeTimeout, 16'h00c8, "reset timeout");
        chk({13'h0, out1Config}, 16'h0000, "reset config");
        resetn = 1'b1;
        enter;
        $display("reset test done");
        foreach (rows[k]) begin
            cmd(rows[k].c, rows[k].w, rows[k].p, 1'h0);
            chk({12'h0, rspError, rspValid, rows[k].n != 2'h0 ? rspLen : 2'h0},
                {12'h0, rows[k].e, rows[k].n != 2'h0, rows[k].n}, "flags");
            if (rows[k].n != 2'h0) chk(rows[k].n == 2'h1 ? {8'h00, rspData[7:0]} : rspData, rows[k].d, "data");
        end
        $display("table test done");
        txt(2'h0, "8000\r", 1'b0);
        upd(8'h10);
        cmd(8'h36, 1'h0, 16'h0000, 1'h0);
        chk(rspData, 16'h0028, "low clamp");
        upd(8'h80);
        cmd(8'h36, 1'h0, 16'h0000, 1'h0);
        chk(rspData, 16'h006e, "high clamp");
        txt(2'h0, "-110dBm\r", 1'b1);
        txt(2'h2, "-110\r", 1'b0);
        upd(8'h58);
        txt(2'h1, "58\r", 1'b0);
        for (int c = 0; c < 5; c++) begin
            cmd(8'h1f, 1'h1, 16'(c), 1'h0);
            for (int k = 0; k < 4; k++) begin
                {ctsAssert, txActive} = 2'(k);
                repeat (2) @(negedge clk);
                x = c == 0 ? !ctsAssert : c == 1 ? !txActive : c == 3 ? txActive : c == 2;
                chk({15'h0, generalOutputOne}, {15'h0, x}, "pin");
            end
        end
        {ctsAssert, txActive} = 2'h0;
        $display("pin test done");
        cmd(8'h09, 1'h0, 16'h0000, 1'h0);
        chk({14'h0, cmdModeActive, exitPulse}, 16'h0001, "exit");
        cmd(8'h06, 1'h0, 16'h0000, 1'h0);
        chk({14'h0, rspValid, rspError}, 16'h0000, "idle command");
        enter;
        cmd(8'h06, 1'h1, 16'h0002, 1'h0);
        repeat (6) begin
            @(negedge clk);
            rxCmdChar = 1'b1;
            @(negedge clk);
            rxCmdChar = 1'b0;
            repeat (3) @(negedge clk);
        end
        chk({15'h0, cmdModeActive}, 16'h0001, "kept alive");
        for (n = 0; n < 40 && cmdModeActive === 1'b1; n++) @(negedge clk);
        chk({15'h0, n >= 4 && n <= 6}, 16'h0001, "idle exit");
        $display("mode test done");
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk(cmdModeTimeout, 16'h00c8, "reset2 timeout");
        chk({13'h0, out1Config}, 16'h0000, "reset2 config");
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        $display("second reset test done");
        stop_test;
    end
endmodule
